// ---- rtl/sit_pkg.sv ----
// Shared constants for the sample interval timer and its processor end
package sit_pkg;
	// Clocking
	localparam int SYS_CLK_HZ = 50_000_000;
	localparam int CNT_CLK_HZ = 6_000_000;
	localparam int CLK_STEP = CNT_CLK_HZ / 1_000_000;
	localparam int CLK_WRAP = SYS_CLK_HZ / 1_000_000;
	localparam logic [5:0] ACC_STEP = 6'(CLK_STEP);
	localparam logic [5:0] ACC_WRAP = 6'(CLK_WRAP);
	// Sample period
	localparam int SAMPLE_PERIOD_MS = 10;
	localparam int PRESET_COUNT = 60_000;
	localparam int LSB_PERIOD_NS = 42_666;
	localparam logic [15:0] COUNT_LOAD = 16'(65_536 - PRESET_COUNT);
	localparam logic [15:0] COUNT_LAST = 16'hFFFF;
	localparam logic [7:0] BYTE_FIRST = 8'h15;
	// Processor end register byte offsets
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_THRESH = 6'h04;
	localparam logic [5:0] OFS_MOVE_LEN = 6'h08;
	localparam logic [5:0] OFS_STATUS = 6'h0C;
	localparam logic [5:0] OFS_MASK = 6'h10;
	localparam logic [5:0] OFS_BYTE = 6'h14;
	localparam logic [5:0] OFS_DMA_ADDR = 6'h18;
	localparam logic [5:0] OFS_DMA_CNT = 6'h1C;
	localparam logic [5:0] OFS_MOVE_SRC = 6'h20;
	// Control fields
	localparam int CTRL_MODE = 0;
	localparam int CTRL_LOW_BAND = 1;
	localparam int CTRL_WB_PEND = 2;
	// Status fields
	localparam int ST_SAMPLE = 0;
	localparam int ST_DONE = 1;
	localparam int ST_SKIP = 2;
	localparam int ST_OVERRUN = 3;
	localparam int ST_W = 4;
	// Reset values
	localparam logic [7:0] THRESH_RESET = 8'h80;
	localparam logic [15:0] MOVE_LEN_RESET = 16'h0010;
endpackage

// ---- rtl/sit_link_if.sv ----
// Link between the timer end and the processor end
`timescale 1ns/1ns
interface sit_link_if;
	logic [7:0] sample_byte;
	logic sample_tick;
	logic sample_irq;
	logic move_mode;
	logic wb_pending;
	logic irq_clear;
	modport dev_mp (
		output sample_byte,
		output sample_tick,
		output sample_irq,
		input move_mode,
		input wb_pending,
		input irq_clear
	);
	modport host_mp (
		input sample_byte,
		input sample_tick,
		input sample_irq,
		output move_mode,
		output wb_pending,
		output irq_clear
	);
endinterface

// ---- rtl/sit_dev.sv ----
// Sample interval timer: 16-bit preset counter and sample interrupt
`timescale 1ns/1ns
// Function
// R1: 16-bit counter advanced at 6 MHz
// R2: preset 60000 at each sample start
// R3: counter triggers sample every 10 ms
// R4: only upper eight bits visible
// R5: visible byte is live, not latched
// R6: software confirms byte by repeated reads
// R7: byte runs 0x15 to 0xFF
// R8: sample raises irq in move mode; here only while wb_pending is also set
// R9: handler moves only below threshold
// R10: handler saves, restores sample DMA state
// R11: handler done before next sample
// R12: assisted moves only in low band
// R13: terminal count triggers and reloads together
module sit_dev (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Processor link
	sit_link_if.dev_mp link,
	// Sample channel side
	output logic sample_start,
	output logic irq_overrun,
	output logic [15:0] sample_seq
);
	import sit_pkg::*;

	logic [5:0] acc_q;
	logic [5:0] acc_d;
	logic tick_q;
	logic tick_d;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic wrap;
	logic irq_q;
	logic irq_d;
	logic tick_out_q;
	logic start_q;
	logic overrun_q;
	logic [15:0] seq_q;
	logic irq_event;

	// Fractional divider from core clock to 6 MHz count rate
	always_comb begin
		acc_d = acc_q + ACC_STEP; // R1
		tick_d = 1'b0;
		if (acc_d >= ACC_WRAP) begin
			acc_d = acc_d - ACC_WRAP;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			acc_q <= 6'h00;
			tick_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			tick_q <= tick_d;
		end
	end

	// Terminal count reached on a count tick
	assign wrap = tick_q && (count_q == COUNT_LAST);

	// Sample counter: counts up from the load to all ones
	always_comb begin
		count_d = count_q;
		if (wrap) begin
			count_d = COUNT_LOAD; // R2 R13
		end else if (tick_q) begin
			count_d = count_q + 16'h0001; // R1
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			count_q <= COUNT_LOAD;
		end else begin
			count_q <= count_d;
		end
	end

	// Upper byte straight off the live count, no snapshot
	assign link.sample_byte = count_q[15:8]; // R4 R5 R7

	// Sample trigger pulses, one cycle wide
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			start_q <= 1'b0;
			tick_out_q <= 1'b0;
		end else begin
			start_q <= wrap; // R3 R13
			tick_out_q <= wrap; // R3
		end
	end

	assign sample_start = start_q;
	assign link.sample_tick = tick_out_q;

	// Sample counter for the acquisition side
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			seq_q <= 16'h0000;
		end else if (wrap) begin
			seq_q <= seq_q + 16'h0001;
		end
	end

	assign sample_seq = seq_q;

	// Interrupt only while assisted moves are wanted
	assign irq_event = wrap && link.move_mode && link.wb_pending;

	// Set wins over a clear in the same cycle
	always_comb begin
		irq_d = irq_q;
		if (link.irq_clear) begin
			irq_d = 1'b0;
		end
		if (irq_event) begin
			irq_d = 1'b1; // R8
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign link.sample_irq = irq_q;

	// Handler still busy when the next sample arrives
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			overrun_q <= 1'b0;
		end else if (irq_event && irq_q && !link.irq_clear) begin
			overrun_q <= 1'b1; // R11
		end
	end

	assign irq_overrun = overrun_q;

endmodule

// ---- rtl/sit_host.sv ----
// Processor end: sample interrupt handler with Avalon-MM registers
`timescale 1ns/1ns
module sit_host (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Timer link
	sit_link_if.host_mp link,
	// Avalon-MM slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Interrupt
	output logic irq
);
	import sit_pkg::*;

	typedef enum logic [2:0] {
		SIT_IDLE = 3'b000,
		SIT_READ_A = 3'b001,
		SIT_READ_B = 3'b010,
		SIT_DECIDE = 3'b011,
		SIT_SAVE = 3'b100,
		SIT_MOVE = 3'b101,
		SIT_RESTORE = 3'b110,
		SIT_CLEAR = 3'b111
	} sit_state_t;

	sit_state_t state_q;
	logic [2:0] ctrl_q;
	logic [7:0] thresh_q;
	logic [15:0] move_len_q;
	logic [15:0] move_src_q;
	logic [ST_W-1:0] status_q;
	logic [ST_W-1:0] mask_q;
	logic [ST_W-1:0] ev;
	logic [7:0] byte_a_q;
	logic [7:0] byte_q;
	logic [15:0] dma_addr_q;
	logic [15:0] dma_cnt_q;
	logic [15:0] save_addr_q;
	logic [15:0] save_cnt_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic irq_q;
	logic clr_q;
	logic wr;

	assign wr = avs_write && !wait_q;

	// One wait state, then the request completes
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= !((avs_read || avs_write) && wait_q);
			if (avs_read && wait_q) begin
				case (avs_address)
					OFS_CTRL: rdata_q <= {29'h0, ctrl_q};
					OFS_THRESH: rdata_q <= {24'h0, thresh_q};
					OFS_MOVE_LEN: rdata_q <= {16'h0, move_len_q};
					OFS_STATUS: rdata_q <= {28'h0, status_q};
					OFS_MASK: rdata_q <= {28'h0, mask_q};
					OFS_BYTE: rdata_q <= {24'h0, byte_q};
					OFS_DMA_ADDR: rdata_q <= {16'h0, dma_addr_q};
					OFS_DMA_CNT: rdata_q <= {16'h0, dma_cnt_q};
					OFS_MOVE_SRC: rdata_q <= {16'h0, move_src_q};
					default: rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign avs_waitrequest = wait_q;
	assign avs_readdata = rdata_q;

	// Plain software settings
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			thresh_q <= THRESH_RESET;
			move_len_q <= MOVE_LEN_RESET;
			move_src_q <= 16'h0000;
			mask_q <= '0;
		end else if (wr) begin
			case (avs_address)
				OFS_THRESH: thresh_q <= avs_writedata[7:0];
				OFS_MOVE_LEN: move_len_q <= avs_writedata[15:0];
				OFS_MOVE_SRC: move_src_q <= avs_writedata[15:0];
				OFS_MASK: mask_q <= avs_writedata[ST_W-1:0];
				default: ;
			endcase
		end
	end

	// Control; a finished move drops the pending flag
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= 3'h0;
		end else if (state_q == SIT_RESTORE) begin
			ctrl_q[CTRL_WB_PEND] <= 1'b0;
		end else if (wr && avs_address == OFS_CTRL) begin
			ctrl_q <= avs_writedata[2:0];
		end
	end

	// Assisted moves only in low band
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			link.move_mode <= 1'b0;
			link.wb_pending <= 1'b0;
		end else begin
			link.move_mode <= ctrl_q[CTRL_MODE] && ctrl_q[CTRL_LOW_BAND]; // R12
			link.wb_pending <= ctrl_q[CTRL_WB_PEND];
		end
	end

	// Handler sequence
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= SIT_IDLE;
			byte_a_q <= 8'h00;
			byte_q <= 8'h00;
			clr_q <= 1'b0;
		end else begin
			clr_q <= 1'b0;
			case (state_q)
				SIT_IDLE: begin
					if (link.sample_irq) begin
						state_q <= SIT_READ_A;
					end
				end
				SIT_READ_A: begin
					byte_a_q <= link.sample_byte;
					state_q <= SIT_READ_B;
				end
				SIT_READ_B: begin
					byte_a_q <= link.sample_byte;
					if (link.sample_byte == byte_a_q) begin
						byte_q <= byte_a_q; // R6
						state_q <= SIT_DECIDE;
					end
				end
				SIT_DECIDE: begin
					if (byte_q < thresh_q && move_len_q != 16'h0000) begin
						state_q <= SIT_SAVE; // R9
					end else begin
						clr_q <= 1'b1;
						state_q <= SIT_CLEAR;
					end
				end
				SIT_SAVE: state_q <= SIT_MOVE;
				SIT_MOVE: begin
					if (dma_cnt_q == 16'h0001) begin
						state_q <= SIT_RESTORE;
					end
				end
				SIT_RESTORE: begin
					clr_q <= 1'b1; // R11
					state_q <= SIT_CLEAR;
				end
				SIT_CLEAR: state_q <= SIT_IDLE;
				default: state_q <= SIT_IDLE;
			endcase
		end
	end

	assign link.irq_clear = clr_q;

	// Sample DMA channel, borrowed for the block move
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			dma_addr_q <= 16'h0000;
			dma_cnt_q <= 16'h0000;
			save_addr_q <= 16'h0000;
			save_cnt_q <= 16'h0000;
		end else if (state_q == SIT_SAVE) begin
			save_addr_q <= dma_addr_q; // R10
			save_cnt_q <= dma_cnt_q; // R10
			dma_addr_q <= move_src_q;
			dma_cnt_q <= move_len_q;
		end else if (state_q == SIT_MOVE) begin
			dma_addr_q <= dma_addr_q + 16'h0001;
			dma_cnt_q <= dma_cnt_q - 16'h0001;
		end else if (state_q == SIT_RESTORE) begin
			dma_addr_q <= save_addr_q; // R10
			dma_cnt_q <= save_cnt_q; // R10
		end else if (wr && avs_address == OFS_DMA_ADDR) begin
			dma_addr_q <= avs_writedata[15:0];
		end else if (wr && avs_address == OFS_DMA_CNT) begin
			dma_cnt_q <= avs_writedata[15:0];
		end else if (link.sample_tick && dma_cnt_q != 16'h0000) begin
			dma_addr_q <= dma_addr_q + 16'h0001;
			dma_cnt_q <= dma_cnt_q - 16'h0001;
		end
	end

	// Events for the sticky status
	always_comb begin
		ev = '0;
		ev[ST_SAMPLE] = link.sample_tick;
		ev[ST_DONE] = state_q == SIT_RESTORE;
		ev[ST_SKIP] = state_q == SIT_DECIDE && !(byte_q < thresh_q
			&& move_len_q != 16'h0000);
		ev[ST_OVERRUN] = link.sample_tick && (state_q == SIT_SAVE
			|| state_q == SIT_MOVE || state_q == SIT_RESTORE); // R11
	end

	// Write one to clear; a new event wins
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			status_q <= '0;
		end else if (wr && avs_address == OFS_STATUS) begin
			status_q <= (status_q & ~avs_writedata[ST_W-1:0]) | ev;
		end else begin
			status_q <= status_q | ev;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_q & mask_q);
		end
	end

	assign irq = irq_q;

endmodule

// ---- testbench/sit_props.sv ----
// Checker for the link between timer end and processor end
`timescale 1ns/1ns
module sit_props (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Link signals
	input wire logic [7:0] sample_byte,
	input wire logic sample_tick,
	input wire logic sample_irq,
	input wire logic move_mode,
	input wire logic wb_pending,
	input wire logic irq_clear
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	logic [18:0] per_q;
	logic seen_q;
	logic [11:0] run_q;
	logic [7:0] prev_q;
	// Cycles since the last sample
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			per_q <= 19'h0;
			seen_q <= 1'b0;
		end else begin
			per_q <= sample_tick ? 19'h0 : per_q + 19'h1;
			seen_q <= seen_q | sample_tick;
		end
	end
	// Cycles since the visible byte last moved
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			run_q <= 12'h0;
			prev_q <= 8'h15;
		end else begin
			run_q <= (sample_byte != prev_q) ? 12'h0 : run_q + 12'h1;
			prev_q <= sample_byte;
		end
	end
	chk_tick_reload: assert property (sample_tick |-> sample_byte == 8'h15)
		else $error("byte not preset at sample");
	chk_tick_wrap: assert property (sample_tick |-> $past(sample_byte) == 8'hFF)
		else $error("sample not at terminal count");
	chk_tick_pulse: assert property (sample_tick |=> !sample_tick)
		else $error("sample tick longer than a cycle");
	chk_period_exact: assert property (sample_tick && seen_q |-> per_q == 19'd499999)
		else $error("sample period wrong");
	chk_byte_step: assert property (!sample_tick && $changed(sample_byte) |-> sample_byte == $past(sample_byte) + 8'h1)
		else $error("byte did not step by one");
	chk_lsb_rate: assert property (!sample_tick && sample_byte != prev_q && prev_q != 8'h15 |-> run_q inside {12'd2132, 12'd2133})
		else $error("byte step rate wrong");
	chk_lsb_bound: assert property (run_q < 12'd2134)
		else $error("byte stalled");
	chk_irq_raise: assert property (sample_tick && $past(move_mode) && $past(wb_pending) |-> sample_irq)
		else $error("sample irq missing");
	chk_irq_cause: assert property ($rose(sample_irq) |-> sample_tick && $past(move_mode) && $past(wb_pending))
		else $error("sample irq without cause");
	chk_irq_drop: assert property (irq_clear |=> !sample_irq || sample_tick)
		else $error("sample irq not cleared");
	cover property (sample_tick && sample_irq);
	cover property (irq_clear);
	cover property (sample_tick && !sample_irq);
endmodule

// ---- testbench/test_sample_interval_timer.sv ----
// Self-checking bench joining timer end and processor end
`timescale 1ns/1ns
module test_sample_interval_timer;
	import sit_pkg::*;
	localparam int LIMIT = 1_300_000;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [5:0] avs_address = 6'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	logic sample_start;
	logic irq_overrun;
	logic [15:0] sample_seq;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [7:0] rnd = 8'h45;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	int starts = 0;
	int i;
	sit_link_if link();
	sit_dev sit_dev_inst (.core_clk(core_clk), .rstn(rstn), .link(link),
		.sample_start(sample_start), .irq_overrun(irq_overrun),
		.sample_seq(sample_seq));
	sit_host sit_host_inst (.core_clk(core_clk), .rstn(rstn), .link(link),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.irq(irq));
	sit_props sit_props_inst (.core_clk(core_clk), .rstn(rstn),
		.sample_byte(link.sample_byte), .sample_tick(link.sample_tick),
		.sample_irq(link.sample_irq), .move_mode(link.move_mode),
		.wb_pending(link.wb_pending), .irq_clear(link.irq_clear));
	always #10 core_clk = ~core_clk;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic compare(input string n, input logic [31:0] e,
		input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic bus(input logic [5:0] a, input logic w,
		input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e,
		input logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		bus(a, 1'b0, 32'h0);
	endtask
	task automatic wait_link(input logic lvl);
		for (i = 0; i < 600000 && link.sample_irq !== lvl; i++) begin
			@(posedge core_clk);
		end
	endtask
	// Timeout and read data monitor
	always @(posedge core_clk) begin
		cycles++;
		if (sample_start === 1'b1) begin
			starts++;
		end
		if (cycles == LIMIT) begin
			failures++;
			final_report();
		end
		if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
			compare("readdata", exp_q.pop_front(),
				avs_readdata & msk_q.pop_front());
		end
	end
	initial begin
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		rd(OFS_THRESH, 32'(THRESH_RESET), 32'hFF);
		rd(OFS_MOVE_LEN, 32'(MOVE_LEN_RESET), 32'hFFFF);
		bus(6'h3C, 1'b1, 32'hFFFFFFFF);
		rd(6'h3C, 32'h0, 32'hFFFFFFFF);
		rnd = lfsr(rnd);
		bus(OFS_DMA_ADDR, 1'b1, {24'h0, rnd});
		bus(OFS_DMA_CNT, 1'b1, 32'h0);
		bus(OFS_MASK, 1'b1, 32'hF);
		bus(OFS_CTRL, 1'b1, 32'h7);
		wait_link(1'b1);
		wait_link(1'b0);
		compare("irq", 32'h1, {31'h0, irq});
		compare("sample_seq", 32'h1, {16'h0, sample_seq});
		rd(OFS_STATUS, 32'h3, 32'hF);
		rd(OFS_CTRL, 32'h3, 32'h7);
		rd(OFS_DMA_ADDR, {24'h0, rnd}, 32'hFF);
		rd(OFS_DMA_CNT, 32'h0, 32'hFFFF);
		bus(OFS_STATUS, 1'b1, 32'hF);
		bus(OFS_MASK, 1'b1, 32'h0);
		rnd = lfsr(rnd);
		bus(OFS_THRESH, 1'b1, {28'h0, rnd[3:0]});
		rd(OFS_THRESH, {28'h0, rnd[3:0]}, 32'hFF);
		rd(OFS_STATUS, 32'h0, 32'hF);
		bus(OFS_CTRL, 1'b1, 32'h7);
		wait_link(1'b1);
		wait_link(1'b0);
		compare("irq", 32'h0, {31'h0, irq});
		rd(OFS_STATUS, 32'h5, 32'hF);
		bus(OFS_MASK, 1'b1, 32'h4);
		repeat (2) @(posedge core_clk);
		compare("irq", 32'h1, {31'h0, irq});
		compare("overrun", 32'h0, {31'h0, irq_overrun});
		compare("sample_seq", 32'h2, {16'h0, sample_seq});
		compare("sample_start", 32'h2, 32'(starts));
		final_report();
	end
endmodule
